/* File: src/dwd_wdt_map.vh */
// Constants for the digital watchdog: offsets, fields, reset values, timing
`ifndef DWD_WDT_MAP_VH
`define DWD_WDT_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DWD_ADR_COUNT      8'hD8
`define DWD_ADR_STATUS     8'hDC

// ----------------------------------------------------------------
// Count/control register fields
// ----------------------------------------------------------------
`define DWD_BIT_ACT        0
`define DWD_BIT_SR         1
`define DWD_REG_RESET      8'hFE
`define DWD_CNT_RESET      7'h7F
`define DWD_CNT_SR_EDGE    7'h40
`define DWD_CNT_ONE        7'h01

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define DWD_ST_ACTIVE      0
`define DWD_ST_STOP        1
`define DWD_ST_WAIT        2
`define DWD_ST_HWOPT       3
`define DWD_ST_EXTOPT      4
`define DWD_ST_HOLD        5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DWD_TICK_CYC       12'd3072
`define DWD_TICK_LAST      12'd3071
`define DWD_STAB_CYC       2048

`endif

/* File: src/dwd_sync2.v */
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module dwd_sync2 (
    input  wire clk_sys,   // System clock
    input  wire rst,       // Async reset, active high
    input  wire asyncIn,   // Level from a pin
    output wire syncOut    // Synchronised level
);
    reg firstQ;
    reg secondQ;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            firstQ  <= 1'b0;
            secondQ <= 1'b0;
        end else begin
            firstQ  <= asyncIn;
            secondQ <= firstQ;
        end
    end

    assign syncOut = secondQ;
endmodule

/* File: src/dwd_prescaler.v */
// Prescaler that emits one tick every 3072 clocks while running
`timescale 1ns/1ps
`include "dwd_wdt_map.vh"
module dwd_prescaler (
    input  wire clk_sys,   // System clock
    input  wire rst,       // Async reset, active high
    input  wire restart,   // Restart the count from zero
    input  wire run,       // Count when high, hold when low
    output wire tick       // One-cycle pulse at end of period
);
    reg [11:0] div_q;

    assign tick = run && !restart && (div_q == `DWD_TICK_LAST);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q <= 12'h000;
        end else if (restart || tick) begin
            div_q <= 12'h000;
        end else if (run) begin
            div_q <= div_q + 12'h001;
        end
    end
endmodule

/* File: src/dwd_watchdog.v */
// Digital watchdog down-counter with Wishbone slave and stop control
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "dwd_wdt_map.vh"
module dwd_watchdog #(
    parameter STAB_CYC = `DWD_STAB_CYC     // Stabilisation delay in clocks
) (
    input  wire        clk_sys,            // System clock, 40 MHz
    input  wire        rst,                // Async reset, active high
    input  wire        wb_cyc_i,           // Wishbone cycle
    input  wire        wb_stb_i,           // Wishbone strobe
    input  wire        wb_we_i,            // Wishbone write enable
    input  wire [7:0]  wb_adr_i,           // Wishbone byte address
    input  wire [3:0]  wb_sel_i,           // Wishbone byte selects
    input  wire [31:0] wb_dat_i,           // Wishbone write data
    output wire [31:0] wb_dat_o,           // Wishbone read data
    output wire        wb_ack_o,           // Wishbone acknowledge
    input  wire        optHwActivation,    // Strap: hardware activation
    input  wire        optExtStopCtl,      // Strap: external stop control
    input  wire        nmiPin,             // NMI pin level
    input  wire        stopInstr,          // Core executes a stop, pulse
    input  wire        irqWakeReq,         // Maskable interrupt request
    input  wire        nmiReq,             // Latched NMI request
    input  wire        global_irq_enable,  // Global interrupt enable
    output wire        cpuWait,            // Core held in wait
    output wire        cpuStop,            // Core held in stop
    output wire        oscEnable,          // Oscillator runs when high
    output wire        sysResetOut,        // Internal system reset
    output wire        resetPinOut,        // Reset pin drive value
    output wire        resetPinOe          // Reset pin drive enable
);
    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam [1:0] ST_RUN  = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_STOP = 2'b10;
    // Last count of the stabilisation hold
    localparam [11:0] STAB_LAST = STAB_CYC[11:0] - 12'h001;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg  [6:0]  countdown_bits_q;
    reg  [6:0]  countdown_bits_d;
    reg         actBit_q;
    reg         actBit_d;
    reg  [1:0]  mode_q;
    reg  [1:0]  mode_d;
    reg         hold_q;
    reg  [11:0] holdCnt_q;
    reg         optHw_q;
    reg         optExt_q;
    reg         optTaken_q;
    reg         ack_q;
    reg  [7:0]  rdData_q;
    reg  [7:0]  rdData_d;
    reg  [1:0]  fill_q;
    reg         cpuWait_q;
    reg         cpuStop_q;
    reg         oscEn_q;
    wire        optHwSync;
    wire        optExtSync;
    wire        nmiSync;
    wire        tick;
    wire        active;
    wire        frozen;
    wire        busReq;
    wire        wrCount;
    wire        swFire;
    wire        cntFire;
    wire        wake;
    wire [7:0]  watchdog_count_control;
    wire [7:0]  statusReg;
    wire [6:0]  wrCount7;

    // ----------------------------------------------------------------
    // Pin and strap synchronisers
    // ----------------------------------------------------------------
    // NMI pin level is only read through its synchroniser
    dwd_sync2 uSyncNmi (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (nmiPin),
        .syncOut (nmiSync)
    );

    dwd_sync2 uSyncHw (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (optHwActivation),
        .syncOut (optHwSync)
    );

    dwd_sync2 uSyncExt (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (optExtStopCtl),
        .syncOut (optExtSync)
    );

    // Straps are caught once, after the synchronisers have filled
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fill_q     <= 2'b00;
            optTaken_q <= 1'b0;
            optHw_q    <= 1'b0;
            optExt_q   <= 1'b0;
        end else if (!optTaken_q) begin
            fill_q <= {fill_q[0], 1'b1};
            if (fill_q[1]) begin
                optTaken_q <= 1'b1;
                optHw_q    <= optHwSync;
                optExt_q   <= optExtSync;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // A request is taken once; the registered ack blocks a second take
    // Writes during the reset hold are acked but dropped
    assign busReq  = wb_cyc_i && wb_stb_i && !ack_q;
    assign wrCount = busReq && wb_we_i && wb_sel_i[0]
                     && (wb_adr_i == `DWD_ADR_COUNT) && !hold_q;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq;
        end
    end

    assign wb_ack_o = ack_q;

    // Register bits are mirrored onto the counter bits
    assign wrCount7 = {wb_dat_i[1], wb_dat_i[2], wb_dat_i[3], wb_dat_i[4],
                       wb_dat_i[5], wb_dat_i[6], wb_dat_i[7]};

    assign watchdog_count_control = {countdown_bits_q[0], countdown_bits_q[1],
                                     countdown_bits_q[2], countdown_bits_q[3],
                                     countdown_bits_q[4], countdown_bits_q[5],
                                     countdown_bits_q[6], active};

    // Status: active, stop, wait, straps and reset hold
    assign statusReg = {2'b00, hold_q, optExt_q, optHw_q,
                        (mode_q == ST_WAIT), (mode_q == ST_STOP), active};

    // Read data is latched at the taking edge and stands with ack
    always @* begin
        case (wb_adr_i)
            `DWD_ADR_COUNT:  rdData_d = watchdog_count_control;
            `DWD_ADR_STATUS: rdData_d = statusReg;
            default:         rdData_d = 8'h00;
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData_q <= 8'h00;
        end else if (busReq && !wb_we_i) begin
            rdData_q <= rdData_d;
        end
    end

    assign wb_dat_o = {24'h000000, rdData_q};

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Counter freezes while the core is in stop
    assign frozen = (mode_q == ST_STOP);

    // Prescaler waits for the straps before its first period
    dwd_prescaler uPresc (
        .clk_sys (clk_sys),
        .rst     (rst),
        .restart (wrCount || hold_q),
        .run     (!frozen && optTaken_q),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // Activation and countdown
    // ----------------------------------------------------------------
    // The hardware strap forces activation regardless of the written bit
    assign active = actBit_q || optHw_q;

    // Writing SR low while it is high fires at once; the countdown fires only when active
    assign swFire  = wrCount && countdown_bits_q[6]
                     && !wb_dat_i[`DWD_BIT_SR];
    assign cntFire = active && tick
                     && (countdown_bits_q == `DWD_CNT_SR_EDGE);

    always @* begin
        countdown_bits_d = countdown_bits_q;
        actBit_d         = actBit_q;
        if (hold_q) begin
            countdown_bits_d = `DWD_CNT_RESET;
            actBit_d         = 1'b0;
        end else if (wrCount) begin
            countdown_bits_d = wrCount7;
            // A write only ever sets the activation bit; the reset hold clears it
            actBit_d = actBit_q || wb_dat_i[`DWD_BIT_ACT];
        end else if (tick) begin
            // Wraps freely as a 7-bit timer when inactive
            countdown_bits_d = countdown_bits_q - `DWD_CNT_ONE;
        end
    end

    // Counter and activation bit registers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            countdown_bits_q <= `DWD_CNT_RESET;
            actBit_q         <= 1'b0;
        end else begin
            countdown_bits_q <= countdown_bits_d;
            actBit_q         <= actBit_d;
        end
    end

    // ----------------------------------------------------------------
    // Reset hold with stabilisation delay
    // ----------------------------------------------------------------
    // A write restarts the prescaler, so a fresh activation always
    // grants a full tick period before any countdown reset
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hold_q    <= 1'b0;
            holdCnt_q <= 12'h000;
        end else if (!hold_q) begin
            if (swFire || cntFire) begin
                hold_q    <= 1'b1;
                holdCnt_q <= 12'h000;
            end
        end else if (holdCnt_q == STAB_LAST) begin
            hold_q    <= 1'b0;
            holdCnt_q <= 12'h000;
        end else begin
            holdCnt_q <= holdCnt_q + 12'h001;
        end
    end

    // The pin is only ever pulled low, never driven high
    assign sysResetOut = hold_q;
    assign resetPinOut = 1'b0;
    assign resetPinOe  = hold_q;

    // ----------------------------------------------------------------
    // Stop and wait control
    // ----------------------------------------------------------------
    // No interrupt, NMI included, wakes the core while interrupts are off
    assign wake = global_irq_enable && (irqWakeReq || nmiReq);

    // Stop becomes wait whenever the counter must keep protecting
    always @* begin
        mode_d = mode_q;
        case (mode_q)
            ST_RUN: begin
                if (stopInstr) begin
                    if (!active) begin
                        mode_d = ST_STOP;
                    end else if (optExt_q && nmiSync) begin
                        mode_d = ST_STOP;
                    end else begin
                        mode_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (wake) begin
                    mode_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (wake) begin
                    mode_d = ST_RUN;
                end
            end
            default: begin
                mode_d = ST_RUN;
            end
        endcase
    end

    // Reset hold returns the core to run
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mode_q <= ST_RUN;
        end else if (hold_q) begin
            mode_q <= ST_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Core control outputs come straight from flops
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpuWait_q <= 1'b0;
            cpuStop_q <= 1'b0;
            oscEn_q   <= 1'b1;
        end else if (hold_q) begin
            cpuWait_q <= 1'b0;
            cpuStop_q <= 1'b0;
            oscEn_q   <= 1'b1;
        end else begin
            cpuWait_q <= (mode_d == ST_WAIT);
            cpuStop_q <= (mode_d == ST_STOP);
            oscEn_q   <= (mode_d != ST_STOP);
        end
    end

    assign cpuWait   = cpuWait_q;
    assign cpuStop   = cpuStop_q;
    assign oscEnable = oscEn_q;
endmodule

/* File: tb/dwd_core_model.sv */
// Processor core stand-in that issues stop and wake requests
`timescale 1ns/1ps
module dwd_core_model (
    input  logic clk_sys,            // System clock
    output logic stopInstr,          // Stop executed
    output logic irqWakeReq,         // Maskable request
    output logic nmiReq,             // Latched NMI request
    output logic global_irq_enable,  // Interrupt enable
    output logic nmiPin              // NMI pin level
);
    initial begin
        stopInstr = 1'h0;
        irqWakeReq = 1'h0;
        nmiReq = 1'h0;
        global_irq_enable = 1'h0;
        nmiPin = 1'h0;
    end
    // One-cycle stop pulse, taken at the next edge
    task automatic execStop();
        stopInstr <= 1'h1;
        @(posedge clk_sys);
        stopInstr <= 1'h0;
    endtask
    // Wake request held for n cycles; enable stays as given
    task automatic wake(input logic gie, input logic useNmi, input int n);
        global_irq_enable <= gie;
        if (useNmi) begin
            nmiReq <= 1'h1;
        end else begin
            irqWakeReq <= 1'h1;
        end
        repeat (n) @(posedge clk_sys);
        nmiReq <= 1'h0;
        irqWakeReq <= 1'h0;
    endtask
    task automatic setNmi(input logic lvl);
        nmiPin <= lvl;
    endtask
endmodule

/* File: tb/dwd_watchdog_sva.sv */
// Concurrent checks on the watchdog top-level ports
`timescale 1ns/1ps
module dwd_watchdog_sva #(
    parameter int STAB_CYC = 2048  // Reset hold length
) (
    input logic        clk_sys,            // Clock
    input logic        rst,                // Reset
    input logic        wb_cyc_i,           // Cycle
    input logic        wb_stb_i,           // Strobe
    input logic [31:0] wb_dat_o,           // Read data
    input logic        wb_ack_o,           // Acknowledge
    input logic        stopInstr,          // Stop pulse
    input logic        irqWakeReq,         // Maskable request
    input logic        nmiReq,             // NMI request
    input logic        global_irq_enable,  // Interrupt enable
    input logic        cpuWait,            // Core waits
    input logic        cpuStop,            // Core stopped
    input logic        oscEnable,          // Oscillator on
    input logic        sysResetOut,        // System reset
    input logic        resetPinOut,        // Pin value
    input logic        resetPinOe          // Pin enable
);
    int holdCnt_q;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            holdCnt_q <= 0;
        end else if (sysResetOut) begin
            holdCnt_q <= holdCnt_q + 1;
        end else begin
            holdCnt_q <= 0;
        end
    end
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_pin_driven_low: assert property (sysResetOut |-> resetPinOe && !resetPinOut)
        else $error("reset pin not driven low during reset");
    a_hold_length: assert property ($fell(sysResetOut) |-> holdCnt_q == STAB_CYC)
        else $error("reset hold length wrong");
    a_osc_off_stop: assert property (oscEnable == !cpuStop)
        else $error("oscillator state does not match stop");
    a_stop_answer: assert property (stopInstr && !cpuStop && !cpuWait && !sysResetOut
        |=> cpuStop || cpuWait)
        else $error("stop instruction not answered");
    a_masked_wake: assert property ((cpuStop || cpuWait) && !global_irq_enable
        && !sysResetOut |=> cpuStop || cpuWait || sysResetOut)
        else $error("woke with interrupts disabled");
    a_wake_exits: assert property ((cpuStop || cpuWait) && global_irq_enable
        && (irqWakeReq || nmiReq) |=> !cpuStop && !cpuWait)
        else $error("wake request did not end stop or wait");
    c_reset: cover property ($rose(sysResetOut));
    c_stop: cover property ($rose(cpuStop));
    c_wait: cover property ($rose(cpuWait));
endmodule

/* File: tb/dwd_watchdog_test.sv */
// Self-checking bench for the digital watchdog
`timescale 1ns/1ps
`include "dwd_wdt_map.vh"
module dwd_watchdog_test;
    localparam int STAB = 16;
    logic        clk_sys = 1'h0;
    logic        rst = 1'h1;
    logic        wb_cyc_i = 1'h0;
    logic        wb_stb_i = 1'h0;
    logic        wb_we_i = 1'h0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, cpuWait, cpuStop, oscEnable, sysResetOut, resetPinOut, resetPinOe;
    logic        optHwActivation = 1'h0;
    logic        optExtStopCtl = 1'h0;
    logic        stopInstr, irqWakeReq, nmiReq, global_irq_enable, nmiPin;
    logic [7:0]  rd;
    logic        rstSeen;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    dwd_watchdog #(.STAB_CYC(STAB)) dut (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .optHwActivation(optHwActivation),
        .optExtStopCtl(optExtStopCtl), .nmiPin(nmiPin), .stopInstr(stopInstr),
        .irqWakeReq(irqWakeReq), .nmiReq(nmiReq), .global_irq_enable(global_irq_enable),
        .cpuWait(cpuWait), .cpuStop(cpuStop), .oscEnable(oscEnable),
        .sysResetOut(sysResetOut), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));
    dwd_core_model core (
        .clk_sys(clk_sys), .stopInstr(stopInstr), .irqWakeReq(irqWakeReq),
        .nmiReq(nmiReq), .global_irq_enable(global_irq_enable), .nmiPin(nmiPin));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        logic ackSeen;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, wd};
        // Ack and data are sampled where settled; they stand until the next edge
        do begin
            @(negedge clk_sys);
            ackSeen = wb_ack_o;
            rd = wb_dat_o[7:0];
            @(posedge clk_sys);
        end while (ackSeen !== 1'h1);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
        wb_sel_i <= 4'h0;
        @(posedge clk_sys);
    endtask
    task automatic waitRst(input logic lvl, input int lim);
        int n = 0;
        @(negedge clk_sys);
        rstSeen = sysResetOut;
        while (rstSeen !== lvl && n < lim) begin
            @(negedge clk_sys);
            rstSeen = sysResetOut;
            n++;
        end
        @(posedge clk_sys);
    endtask
    task automatic doReset(input logic hw, input logic ext);
        rst <= 1'h1;
        optHwActivation <= hw;
        optExtStopCtl <= ext;
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (4) @(posedge clk_sys);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic tTimer();
        wbXfer(1'h0, `DWD_ADR_COUNT, 8'h00);
        chk(rd, `DWD_REG_RESET);
        wbXfer(1'h0, 8'h10, 8'h00);
        chk(rd, 8'h00);
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'h06);
        repeat (`DWD_TICK_CYC + 8) @(posedge clk_sys);
        chk({7'h0, sysResetOut}, 8'h00);
        wbXfer(1'h0, `DWD_ADR_COUNT, 8'h00);
        chk(rd, 8'hFA);
        wbXfer(1'h0, `DWD_ADR_STATUS, 8'h00);
        chk(rd, 8'h00);
    endtask
    task automatic tActivate();
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'h03);
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'h02);
        wbXfer(1'h0, `DWD_ADR_STATUS, 8'h00);
        chk(rd, 8'h01);
        repeat (2000) @(posedge clk_sys);
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'h02);
        repeat (`DWD_TICK_CYC - 20) @(posedge clk_sys);
        chk({7'h0, sysResetOut}, 8'h00);
        waitRst(1'h1, 40);
        chk({7'h0, rstSeen}, 8'h01);
        waitRst(1'h0, STAB + 10);
        chk({7'h0, rstSeen}, 8'h00);
        wbXfer(1'h0, `DWD_ADR_COUNT, 8'h00);
        chk(rd, `DWD_REG_RESET);
    endtask
    task automatic tSoftRst();
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'hFD);
        waitRst(1'h1, 5);
        chk({7'h0, rstSeen}, 8'h01);
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'h02);
        wbXfer(1'h0, `DWD_ADR_STATUS, 8'h00);
        chk(rd, 8'h20);
        waitRst(1'h0, STAB + 10);
        chk({7'h0, rstSeen}, 8'h00);
        wbXfer(1'h0, `DWD_ADR_COUNT, 8'h00);
        chk(rd, `DWD_REG_RESET);
    endtask
    task automatic tStop(input logic useNmi, input logic expStop);
        core.execStop();
        @(posedge clk_sys);
        chk({6'h0, cpuStop, cpuWait}, expStop ? 8'h02 : 8'h01);
        chk({7'h0, oscEnable}, {7'h0, !expStop});
        core.wake(1'h0, useNmi, 5);
        chk({6'h0, cpuStop, cpuWait}, expStop ? 8'h02 : 8'h01);
        core.wake(1'h1, useNmi, 2);
        chk({6'h0, cpuStop, cpuWait}, 8'h00);
    endtask
    task automatic tHardware();
        doReset(1'h1, 1'h0);
        wbXfer(1'h0, `DWD_ADR_COUNT, 8'h00);
        chk(rd, 8'hFF);
        wbXfer(1'h1, `DWD_ADR_COUNT, 8'hFE);
        wbXfer(1'h0, `DWD_ADR_STATUS, 8'h00);
        chk(rd, 8'h09);
        tStop(1'h1, 1'h0);
        doReset(1'h1, 1'h1);
        core.setNmi(1'h1);
        repeat (4) @(posedge clk_sys);
        tStop(1'h0, 1'h1);
        core.setNmi(1'h0);
        repeat (4) @(posedge clk_sys);
        tStop(1'h1, 1'h0);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        doReset(1'h0, 1'h0);
        tTimer();
        tActivate();
        tSoftRst();
        tStop(1'h0, 1'h1);
        tHardware();
        complete_run();
    end
endmodule
bind dwd_watchdog dwd_watchdog_sva #(.STAB_CYC(STAB_CYC)) uChk (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stopInstr(stopInstr),
    .irqWakeReq(irqWakeReq), .nmiReq(nmiReq), .global_irq_enable(global_irq_enable),
    .cpuWait(cpuWait), .cpuStop(cpuStop), .oscEnable(oscEnable),
    .sysResetOut(sysResetOut), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));
